// ==== shared/adc_consts.svh ====
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// ****************************************
// command codes
// ****************************************
`define CMD_RESET      4'h0
`define CMD_LAST_CHAN  4'h7
`define CMD_PWR_DOWN   4'h8
`define CMD_FAST       4'h9
`define CMD_SLOW       4'ha
`define CMD_TEST_MID   4'hb
`define CMD_TEST_LO    4'hc
`define CMD_TEST_HI    4'hd

// ****************************************
// fixed self-test results and converter
// ****************************************
`define RES_TEST_MID   10'h200
`define RES_TEST_LO    10'h000
`define RES_TEST_HI    10'h3ff
`define SAR_FIRST      10'h200
`define SAR_MSB        4'h9
`define RES_RESET      10'h000
`define RES_BITS       10

// ****************************************
// serial edge positions
// ****************************************
`define CMD_BITS       5'h04
`define ACQ_EDGE_PREV  5'h03
`define HOLD_EDGE_PREV 5'h09
`define EDGE_CNT_MAX   5'h1f

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS  40
`define START_DELAY    2
`define CONV_FAST_NS   7000
`define CONV_SLOW_NS   15000
`define BIT_CYC_FAST   (`CONV_FAST_NS / (`CLK_PERIOD_NS * `RES_BITS))
`define BIT_CYC_SLOW   (`CONV_SLOW_NS / (`CLK_PERIOD_NS * `RES_BITS))

`endif

// ==== shared/adc_pkg.sv ====
`include "adc_consts.svh"

package adc_pkg;

  typedef enum logic [2:0]
  {
    CONV_IDLE  = 3'b001,
    CONV_DELAY = 3'b010,
    CONV_RUN   = 3'b100
  } conv_state_type;

  typedef enum logic [1:0]
  {
    SAR_IDLE = 2'b01,
    SAR_RUN  = 2'b10
  } sar_state_type;

  function automatic logic is_test_cmd(input logic [3:0] c);
    return (c >= `CMD_TEST_MID) && (c <= `CMD_TEST_HI);
  endfunction

  function automatic logic is_sample_cmd(input logic [3:0] c);
    return (c <= `CMD_LAST_CHAN) || is_test_cmd(c);
  endfunction

  function automatic logic [9:0] test_code(input logic [3:0] c);
    logic [9:0] r;
    r = `RES_TEST_HI;
    if (c == `CMD_TEST_MID)
      r = `RES_TEST_MID;
    else if (c == `CMD_TEST_LO)
      r = `RES_TEST_LO;
    return r;
  endfunction

endpackage

// ==== rtl/sar_engine.sv ====
`timescale 1ns/100ps
`include "adc_consts.svh"

module sar_engine
  import adc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       rate_slow,
  input  wire logic       cmp_below,
  input  wire logic [3:0] sel,
  output logic [9:0]      trial_ff,
  output logic            busy,
  output logic            done_ff,
  output logic [9:0]      code_ff
);

  sar_state_type state_ff;
  logic [3:0]    bit_ff;
  logic [5:0]    step_ff;
  logic [3:0]    sel_ff;
  logic          step_end;
  logic          last_end;

  // rate is read live so a new rate acts within the running cycle
  assign step_end = (state_ff == SAR_RUN) &&
                    (step_ff == (rate_slow ? 6'(`BIT_CYC_SLOW - 1) : 6'(`BIT_CYC_FAST - 1)));
  assign last_end = step_end && (bit_ff == 4'h0);
  assign busy     = (state_ff == SAR_RUN);

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      state_ff <= SAR_IDLE;
    else if (abort)
      state_ff <= SAR_IDLE;
    else if (start)
      state_ff <= SAR_RUN;
    else if (last_end)
      state_ff <= SAR_IDLE;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      step_ff <= 6'h00;
    else if (start || abort || step_end || !busy)
      step_ff <= 6'h00;
    else
      step_ff <= step_ff + 6'h01;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      bit_ff <= `SAR_MSB;
      sel_ff <= `CMD_RESET;
    end
    else if (start)
    begin
      bit_ff <= `SAR_MSB;
      sel_ff <= sel;
    end
    else if (step_end && bit_ff != 4'h0)
      bit_ff <= bit_ff - 4'h1;

  // msb first: keep the trial bit when the node sits below the trip point
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      trial_ff <= `RES_RESET;
    else if (start)
      trial_ff <= `SAR_FIRST;
    else if (step_end)
    begin
      trial_ff[bit_ff] <= cmp_below;
      if (bit_ff != 4'h0)
        trial_ff[bit_ff - 4'h1] <= 1'b1;
    end

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      done_ff <= 1'b0;
      code_ff <= `RES_RESET;
    end
    else
    begin
      done_ff <= last_end && !abort;
      if (last_end)
        code_ff <= is_test_cmd(sel_ff) ? test_code(sel_ff) : {trial_ff[9:1], cmp_below};
    end

  AST_SAR_FIRST_TRIAL: assert property (@(posedge core_clk) disable iff (rst)
    start && !abort |=> trial_ff == `SAR_FIRST)
    else $error("first trial is not weight 512");

  AST_SAR_BIT_KEEP: assert property (@(posedge core_clk) disable iff (rst)
    step_end && !start && !abort |=> trial_ff[$past(bit_ff)] == $past(cmp_below))
    else $error("trial bit not resolved from comparator");

endmodule

// ==== rtl/serial_adc_sampling_control.sv ====
`timescale 1ns/100ps
`include "adc_consts.svh"

module serial_adc_sampling_control
  import adc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       io_clk,
  input  wire logic       cs_n,
  input  wire logic       frame_sync,
  input  wire logic       data_in,
  input  wire logic       sample_start_n,
  input  wire logic       cmp_below,
  output logic [3:0]      mux_sel,
  output logic            mux_connect,
  output logic            sampling,
  output logic [9:0]      dac_trial,
  output logic            eoc,
  output logic [9:0]      result,
  output logic            result_valid,
  output logic            power_down,
  output logic            rate_slow,
  output logic            extended_cycle_flag,
  output logic [3:0]      cmd_word
);

  // ****************************************
  // link side, on the serial clock
  // ****************************************
  logic       link_rst;
  logic [4:0] rise_cnt_ff;
  logic [4:0] fall_cnt_ff;
  logic       dsp_mode_ff;
  logic [3:0] shift_cmd_ff;
  logic       acq_rise_ff;
  logic       acq_fall_ff;
  logic       held_ff;
  logic       hold_tgl_ff;
  logic       acq_link;

  // chip select high clears the frame; the serial clock may stop meanwhile
  assign link_rst = rst | cs_n;
  assign acq_link = (acq_rise_ff | acq_fall_ff) & ~held_ff;

  always_ff @(posedge io_clk or posedge link_rst)
    if (link_rst)
      rise_cnt_ff <= 5'h00;
    else if (rise_cnt_ff != `EDGE_CNT_MAX)
      rise_cnt_ff <= rise_cnt_ff + 5'h01;

  always_ff @(negedge io_clk or posedge link_rst)
    if (link_rst)
      fall_cnt_ff <= 5'h00;
    else if (fall_cnt_ff != `EDGE_CNT_MAX)
      fall_cnt_ff <= fall_cnt_ff + 5'h01;

  always_ff @(posedge io_clk or posedge link_rst)
    if (link_rst)
      dsp_mode_ff <= 1'b0;
    else if (rise_cnt_ff == 5'h00)
      dsp_mode_ff <= ~frame_sync;

  // not cleared by chip select so the core can read it after the frame
  always_ff @(posedge io_clk or posedge rst)
    if (rst)
      shift_cmd_ff <= `CMD_RESET;
    else if (!cs_n && rise_cnt_ff < `CMD_BITS)
      shift_cmd_ff <= {shift_cmd_ff[2:0], data_in};

  always_ff @(posedge io_clk or posedge link_rst)
    if (link_rst)
      acq_rise_ff <= 1'b0;
    else if (!dsp_mode_ff && rise_cnt_ff == `ACQ_EDGE_PREV)
      acq_rise_ff <= 1'b1;

  always_ff @(negedge io_clk or posedge link_rst)
    if (link_rst)
      acq_fall_ff <= 1'b0;
    else if (dsp_mode_ff && fall_cnt_ff == `ACQ_EDGE_PREV)
      acq_fall_ff <= 1'b1;

  always_ff @(negedge io_clk or posedge link_rst)
    if (link_rst)
      held_ff <= 1'b0;
    else if (fall_cnt_ff == `HOLD_EDGE_PREV)
      held_ff <= 1'b1;

  always_ff @(negedge io_clk or posedge rst)
    if (rst)
      hold_tgl_ff <= 1'b0;
    else if (!cs_n && fall_cnt_ff == `HOLD_EDGE_PREV)
      hold_tgl_ff <= ~hold_tgl_ff;

  // ****************************************
  // crossings into the core clock
  // ****************************************
  logic cs_s1_ff;
  logic cs_s2_ff;
  logic cs_s3_ff;
  logic ss_s1_ff;
  logic ss_s2_ff;
  logic ss_s3_ff;
  logic acq_s1_ff;
  logic acq_s2_ff;
  logic acq_s3_ff;
  logic hold_s1_ff;
  logic hold_s2_ff;
  logic hold_s3_ff;
  logic cs_fall;
  logic cs_rise;
  logic ss_fall;
  logic ss_rise;
  logic acq_evt;
  logic hold_evt;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      cs_s1_ff   <= 1'b1;
      cs_s2_ff   <= 1'b1;
      cs_s3_ff   <= 1'b1;
      ss_s1_ff   <= 1'b1;
      ss_s2_ff   <= 1'b1;
      ss_s3_ff   <= 1'b1;
      acq_s1_ff  <= 1'b0;
      acq_s2_ff  <= 1'b0;
      acq_s3_ff  <= 1'b0;
      hold_s1_ff <= 1'b0;
      hold_s2_ff <= 1'b0;
      hold_s3_ff <= 1'b0;
    end
    else
    begin
      cs_s1_ff   <= cs_n;
      cs_s2_ff   <= cs_s1_ff;
      cs_s3_ff   <= cs_s2_ff;
      ss_s1_ff   <= sample_start_n;
      ss_s2_ff   <= ss_s1_ff;
      ss_s3_ff   <= ss_s2_ff;
      acq_s1_ff  <= acq_link;
      acq_s2_ff  <= acq_s1_ff;
      acq_s3_ff  <= acq_s2_ff;
      hold_s1_ff <= hold_tgl_ff;
      hold_s2_ff <= hold_s1_ff;
      hold_s3_ff <= hold_s2_ff;
    end

  assign cs_fall  = cs_s3_ff & ~cs_s2_ff;
  assign cs_rise  = ~cs_s3_ff & cs_s2_ff;
  assign ss_fall  = ss_s3_ff & ~ss_s2_ff;
  assign ss_rise  = ~ss_s3_ff & ss_s2_ff;
  assign acq_evt  = acq_s2_ff & ~acq_s3_ff;
  assign hold_evt = hold_s2_ff ^ hold_s3_ff;

  // ****************************************
  // command word and modes
  // ****************************************
  logic [3:0] cmd_ff;
  logic       power_down_ff;
  logic       rate_slow_ff;
  logic       flag_ff;
  logic       allowed_ff;
  logic       sample_ok;

  // shift word is stable by the acquisition edge, which is well before its next change
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      cmd_ff <= `CMD_RESET;
    else if (acq_evt)
      cmd_ff <= shift_cmd_ff;

  // set wins when the power-down command meets a chip select fall
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      power_down_ff <= 1'b0;
    else if (acq_evt && shift_cmd_ff == `CMD_PWR_DOWN)
      power_down_ff <= 1'b1;
    else if (cs_fall)
      power_down_ff <= 1'b0;

  // power-down leaves the rate alone
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      rate_slow_ff <= 1'b0;
    else if (acq_evt && shift_cmd_ff == `CMD_FAST)
      rate_slow_ff <= 1'b0;
    else if (acq_evt && shift_cmd_ff == `CMD_SLOW)
      rate_slow_ff <= 1'b1;

  // starts high: software must clear it once after power-up
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      flag_ff <= 1'b1;
    else if (ss_fall)
      flag_ff <= 1'b1;
    else if (cs_rise)
      flag_ff <= 1'b0;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      allowed_ff <= 1'b0;
    else if (cs_fall)
      allowed_ff <= ~flag_ff;

  assign sample_ok = is_sample_cmd(cmd_ff) && !power_down_ff;

  // ****************************************
  // break-before-make input selection
  // ****************************************
  logic [3:0] mux_sel_ff;
  logic       mux_connect_ff;
  logic       sampling_ff;

  // address is taken even in a read-out-only cycle
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      mux_connect_ff <= 1'b1;
    else
      mux_connect_ff <= ~(acq_evt && is_sample_cmd(shift_cmd_ff) &&
                          shift_cmd_ff != mux_sel_ff);

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      mux_sel_ff <= `CMD_RESET;
    else if (!mux_connect_ff)
      mux_sel_ff <= cmd_ff;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      sampling_ff <= 1'b0;
    else if (!ss_s2_ff)
      sampling_ff <= mux_connect_ff;
    else
      // first acquisition cycle still sees the previous command word
      sampling_ff <= acq_s2_ff && !acq_evt && allowed_ff && sample_ok &&
                     mux_connect_ff;

  // ****************************************
  // conversion sequencing
  // ****************************************
  conv_state_type conv_ff;
  logic [1:0]     dly_ff;
  logic           normal_go;
  logic           eng_start;
  logic           eng_busy;
  logic           eng_done;
  logic [9:0]     eng_code;
  logic [9:0]     eng_trial;
  logic           eoc_ff;
  logic [9:0]     result_ff;
  logic           result_valid_ff;

  assign normal_go = hold_evt && allowed_ff && sample_ok && ss_s2_ff;
  assign eng_start = !ss_fall &&
                     (((conv_ff == CONV_IDLE) && normal_go && !ss_rise) ||
                      ((conv_ff == CONV_DELAY) && dly_ff == 2'(`START_DELAY - 1)));

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      conv_ff <= CONV_IDLE;
    else if (ss_fall)
      conv_ff <= CONV_IDLE;
    else
      unique case (conv_ff)
        CONV_IDLE:
          if (ss_rise)
            conv_ff <= CONV_DELAY;
          else if (normal_go)
            conv_ff <= CONV_RUN;
        CONV_DELAY:
          if (dly_ff == 2'(`START_DELAY - 1))
            conv_ff <= CONV_RUN;
        CONV_RUN:
          if (eng_done)
            conv_ff <= CONV_IDLE;
      endcase

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      dly_ff <= 2'h0;
    else if (conv_ff != CONV_DELAY)
      dly_ff <= 2'h0;
    else
      dly_ff <= dly_ff + 2'h1;

  sar_engine u_sar
  (
    .core_clk  (core_clk),
    .rst       (rst),
    .start     (eng_start),
    .abort     (ss_fall),
    .rate_slow (rate_slow_ff),
    .cmp_below (cmp_below),
    .sel       (mux_sel_ff),
    .trial_ff  (eng_trial),
    .busy      (eng_busy),
    .done_ff   (eng_done),
    .code_ff   (eng_code)
  );

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      eoc_ff <= 1'b1;
    else if (eng_start)
      eoc_ff <= 1'b0;
    else if (eng_done || ss_fall)
      eoc_ff <= 1'b1;

  // a fresh extended sample throws the unread result away
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      result_ff       <= `RES_RESET;
      result_valid_ff <= 1'b0;
    end
    else if (ss_fall)
      result_valid_ff <= 1'b0;
    else if (eng_done)
    begin
      result_ff       <= eng_code;
      result_valid_ff <= 1'b1;
    end

  assign mux_sel             = mux_sel_ff;
  assign mux_connect         = mux_connect_ff;
  assign sampling            = sampling_ff;
  assign dac_trial           = eng_trial;
  assign eoc                 = eoc_ff;
  assign result              = result_ff;
  assign result_valid        = result_valid_ff;
  assign power_down          = power_down_ff;
  assign rate_slow           = rate_slow_ff;
  assign extended_cycle_flag = flag_ff;
  assign cmd_word            = cmd_ff;

  // ****************************************
  // checks
  // ****************************************
  sequence ext_release;
    ss_rise && !ss_fall && conv_ff == CONV_IDLE;
  endsequence

  sequence start_then_run;
    eng_start ##1 (!eoc_ff && conv_ff == CONV_RUN);
  endsequence

  AST_EXT_START_DELAY: assert property (@(posedge core_clk) disable iff (rst)
    ext_release |-> !eng_start ##1 !eng_start ##1 eng_start)
    else $error("extended conversion did not start two clocks after release");

  AST_EOC_LOW_RUN: assert property (@(posedge core_clk) disable iff (rst)
    eng_start |-> start_then_run)
    else $error("end-of-conversion not low while converting");

  AST_EOC_DONE: assert property (@(posedge core_clk) disable iff (rst)
    eng_done && !ss_fall |=> eoc_ff && result_valid_ff && result_ff == $past(eng_code))
    else $error("result not stored with end-of-conversion high");

  AST_DISCARD: assert property (@(posedge core_clk) disable iff (rst)
    ss_fall |=> !result_valid_ff && conv_ff == CONV_IDLE && flag_ff)
    else $error("sample-start did not discard result");

  AST_FLAG_TEST: assert property (@(posedge core_clk) disable iff (rst)
    cs_fall |=> allowed_ff == !$past(flag_ff))
    else $error("flag not tested at chip select fall");

  AST_READOUT_ONLY: assert property (@(posedge core_clk) disable iff (rst)
    hold_evt && !allowed_ff && conv_ff == CONV_IDLE |-> !eng_start)
    else $error("conversion in a read-out-only cycle");

  AST_FLAG_UPDATE: assert property (@(posedge core_clk) disable iff (rst)
    cs_rise && !ss_fall |=> !flag_ff)
    else $error("flag not updated at chip select rise");

  AST_POWER_DOWN: assert property (@(posedge core_clk) disable iff (rst)
    acq_evt && shift_cmd_ff == `CMD_PWR_DOWN |=> power_down_ff && !eng_busy ##1 !eng_busy)
    else $error("power-down command not taken");

  AST_RATE_KEEP: assert property (@(posedge core_clk) disable iff (rst)
    $changed(rate_slow_ff) |-> $past(acq_evt) &&
      ($past(shift_cmd_ff) == `CMD_FAST || $past(shift_cmd_ff) == `CMD_SLOW))
    else $error("rate changed without a rate command");

  AST_BREAK_MAKE: assert property (@(posedge core_clk) disable iff (rst)
    $changed(mux_sel_ff) |-> !$past(mux_connect_ff) && !$past(sampling_ff))
    else $error("input switched without breaking first");

endmodule

// ==== testbench/host_port.sv ====
`timescale 1ns/100ps

// ****************************************
// host serial port model
// ****************************************
module host_port
(
  output logic io_clk,
  output logic cs_n,
  output logic frame_sync,
  output logic data_in,
  output logic sample_start_n
);
  initial
  begin
    io_clk         = 1'b0;
    cs_n           = 1'b1;
    frame_sync     = 1'b1;
    data_in        = 1'b0;
    sample_start_n = 1'b1;
  end

  // clock stands still between frames; released data toggles every period
  task automatic frame(input logic [3:0] c, input logic dsp);
    begin
      #7;
      cs_n       = 1'b0;
      frame_sync = ~dsp;
      data_in    = c[3];
      for (int i = 0; i < 16; i++)
      begin
        #15 io_clk = 1'b1;
        #15 io_clk = 1'b0;
        data_in = (i < 3) ? c[2 - i] : ~data_in;
      end
      #15 cs_n = 1'b1;
      frame_sync = 1'b1;
      data_in    = ~data_in;
    end
  endtask

  // only called while select is high
  task automatic start_level(input logic v);
    sample_start_n = v;
  endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
`include "adc_consts.svh"

module tb;
  logic       core_clk = 1'b0;
  logic       rst      = 1'b1;
  logic [9:0] vin      = 10'h000;
  logic       cmp_below;
  logic       io_clk, cs_n, frame_sync, data_in, sample_start_n;
  logic [3:0] mux_sel, cmd_word;
  logic       mux_connect, sampling, eoc, result_valid;
  logic       power_down, rate_slow, extended_cycle_flag;
  logic [9:0] dac_trial, result;
  int         err_count = 0;
  int         n_tests   = 0;
  int         low_cnt   = 0;
  int         samp_cnt  = 0;
  int         brk_cnt   = 0;
  logic [3:0] sel_exp   = 4'h0;
  int         cyc       = 0;
  int         lo_b      = 168;
  int         hi_b      = 185;
  int         i;
  logic [3:0] cl [0:4] = '{4'h3, 4'hb, 4'hc, 4'hd, 4'h7};
  logic [9:0] xl [0:4] = '{10'h2a5, 10'h200, 10'h000, 10'h3ff, 10'h15a};

  // comparator: node below trip point when input at or above the trial
  assign cmp_below = (vin >= dac_trial);

  host_port host (.io_clk(io_clk), .cs_n(cs_n), .frame_sync(frame_sync),
                  .data_in(data_in), .sample_start_n(sample_start_n));

  serial_adc_sampling_control uut (.core_clk(core_clk), .rst(rst), .io_clk(io_clk),
    .cs_n(cs_n), .frame_sync(frame_sync), .data_in(data_in),
    .sample_start_n(sample_start_n), .cmp_below(cmp_below), .mux_sel(mux_sel),
    .mux_connect(mux_connect), .sampling(sampling), .dac_trial(dac_trial), .eoc(eoc),
    .result(result), .result_valid(result_valid), .power_down(power_down),
    .rate_slow(rate_slow), .extended_cycle_flag(extended_cycle_flag),
    .cmd_word(cmd_word));

  always #20 core_clk = ~core_clk;

  // counted on the falling edge, away from the edge that launches the outputs
  always @(negedge core_clk)
  begin
    cyc <= cyc + 1;
    if (eoc === 1'b0)
      low_cnt <= low_cnt + 1;
    if (sampling === 1'b1)
      samp_cnt <= samp_cnt + 1;
    if (mux_connect === 1'b0)
      brk_cnt <= brk_cnt + 1;
    if (cyc == 12000)
    begin
      err_count++;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // one frame; waits for the conversion it should start, if any
  task automatic run(input logic [3:0] c, input logic d, input logic cv, input int ex);
    int k;
    logic brk_exp;
    begin
      brk_exp  = (c <= `CMD_LAST_CHAN || (c >= `CMD_TEST_MID && c <= `CMD_TEST_HI)) &&
                 c != sel_exp;
      low_cnt  = 0;
      samp_cnt = 0;
      brk_cnt  = 0;
      host.frame(c, d);
      for (k = 0; k < 800 && (eoc !== 1'b1 || (cv && low_cnt == 0)); k++)
        tick(1);
      tick(10);
      check(16'(cmd_word), 16'(c));
      check(16'(brk_cnt), 16'(brk_exp));
      if (brk_exp)
        sel_exp = c;
      check(16'(low_cnt > 0), 16'(cv));
      check(16'(samp_cnt > 0), 16'(cv));
      if (cv)
      begin
        check(16'(mux_sel), 16'(c));
        check(16'(low_cnt >= lo_b && low_cnt <= hi_b), 16'h0001);
        check(16'(result_valid), 16'h0001);
        if (ex >= 0)
          check(16'(result), 16'(ex));
      end
      $display("test cmd %h done", c);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    tick(5);
    rst = 1'b0;
    tick(4);
    check(16'(eoc), 16'h0001);
    check(16'(cmd_word), 16'h0000);
    check(16'(extended_cycle_flag), 16'h0001);
    // first frame after reset is read-out only; it must start no conversion
    run(`CMD_FAST, 1'b0, 1'b0, -1);
    check(16'(extended_cycle_flag), 16'h0000);
    check(16'(rate_slow), 16'h0000);
    for (i = 0; i < 5; i++)
    begin
      // test selections see the inverted input, so a forced result shows
      vin = xl[i] ^ {10{cl[i][3]}};
      run(cl[i], i == 4, 1'b1, int'(xl[i]));
    end
    run(`CMD_SLOW, 1'b0, 1'b0, -1);
    check(16'(rate_slow), 16'h0001);
    lo_b = 368;
    hi_b = 390;
    vin  = 10'h0f3;
    run(4'h5, 1'b0, 1'b1, int'(vin));
    run(`CMD_PWR_DOWN, 1'b0, 1'b0, -1);
    check(16'(power_down), 16'h0001);
    run(4'h2, 1'b0, 1'b1, -1);
    check(16'(power_down), 16'h0000);
    check(16'(rate_slow), 16'h0001);
    run(`CMD_FAST, 1'b0, 1'b0, -1);
    check(16'(rate_slow), 16'h0000);
    lo_b = 168;
    hi_b = 185;
    vin  = 10'h31c;
    // extended sampling on the channel left selected
    host.start_level(1'b0);
    tick(12);
    check(16'(sampling), 16'h0001);
    check(16'(result_valid), 16'h0000);
    check(16'(extended_cycle_flag), 16'h0001);
    host.start_level(1'b1);
    for (i = 0; i < 20 && eoc !== 1'b0; i++)
      tick(1);
    check(16'(i >= 5 && i <= 7), 16'h0001);
    check(16'(sampling), 16'h0000);
    for (i = 0; i < 800 && eoc !== 1'b1; i++)
      tick(1);
    check(16'(result), 16'(vin));
    $display("test extended done");
    run(4'h6, 1'b0, 1'b0, -1);
    check(16'(result), 16'(vin));
    check(16'(extended_cycle_flag), 16'h0000);
    vin = 10'h0a7;
    run(4'h6, 1'b0, 1'b1, int'(vin));
    finish_test();
  end
endmodule
